/* core/his_irq.sv */
// Host controller interrupt event flags, enables and request
//
// Behaviour
// - Any root port status change sets bit 6
// - Frame number bit 15 toggle sets bit 5
// - Fatal error means halt all processing
// - Fatal error flag never set, reads zero
// - Resume flag on new resume, not software
// - Frame start sets bit 2, issues token
// - Overrun sets bit 0, bumps 2-bit count
// - Interrupt needs flag, its enable, master gate
// - Each enable gates same-position flag
// - Enable write one sets, zero keeps
// - Master gate ignores zero, one enables
// - Enable register read 04, written 84
// - Flag cleared by writing one only
// - Flag register read 03, written 83
module his_irq #(
	parameter int NUM_PORTS = 2,
	parameter int PORT_W    = 32
) (
	input  wire logic                          I_REF_CLK,          // Controller clock, 40 MHz
	input  wire logic                          I_RST,              // Hardware reset, sync, high
	input  wire logic                          I_SW_RESET,         // Software reset request, sync, high
	input  wire logic                          I_CMD_VALID,        // Register port command strobe
	input  wire logic [7:0]                    I_CMD_CODE,         // Register port command code
	input  wire logic [31:0]                   I_WR_DATA,          // Register port write data
	input  wire logic [NUM_PORTS*PORT_W-1:0]   I_ROOT_PORT_STATUS, // root_port_status_register words
	input  wire logic [15:0]                   I_FRAME_NUMBER,     // frame_number_register value
	input  wire logic                          I_RESUME_LINE,      // Downstream resume seen on the line
	input  wire logic                          I_BUS_RESUME_STATE, // Software placed bus_resume_state
	input  wire logic                          I_FRAME_START,      // Start of frame pulse
	input  wire logic                          I_SCHED_OVERRUN,    // Schedule overrun pulse
	output logic      [31:0]                   O_RD_DATA,          // Register port read data
	output logic                               O_RD_VALID,         // Read data valid pulse
	output logic                               O_IRQ,              // Hardware interrupt request
	output logic                               O_SOF_TOKEN,        // Issue start-of-frame token pulse
	output logic      [1:0]                    O_OVERRUN_COUNT,    // Overrun count field
	output logic                               O_PROCESS_HALT      // Stop processing and signalling
);

	if (NUM_PORTS < 1 || PORT_W < 1) begin : g_check
		$error("his_irq needs at least one port of nonzero width");
	end

	localparam int ST_W = NUM_PORTS * PORT_W;

	function automatic logic code_hit(input logic valid, input logic [7:0] code, input logic [7:0] want);
		code_hit = valid && (code == want);
	endfunction

	logic              rst;
	logic              wr_flags;
	logic              wr_mask;
	logic              rd_any;
	logic [ST_W-1:0]   port_prev_q;
	logic [NUM_PORTS-1:0] port_changed;
	logic              fmsb_prev_q;
	logic              resume_s1_q;
	logic              resume_s2_q;
	logic              resume_prev_q;
	logic              resume_rise;
	logic [31:0]       set_vec;
	logic [31:0]       clr_vec;
	logic [31:0]       flags_q;
	logic [31:0]       flags_d;
	logic [31:0]       enable_q;
	logic [31:0]       enable_d;
	logic [1:0]        ovr_cnt_q;
	logic [31:0]       rd_word;

	// Software reset clears the same state as hardware reset
	assign rst      = I_RST | I_SW_RESET;
	assign wr_flags = code_hit(I_CMD_VALID, I_CMD_CODE, his_pkg::CMD_WR_FLAGS);
	assign wr_mask  = code_hit(I_CMD_VALID, I_CMD_CODE, his_pkg::CMD_WR_MASK);
	assign rd_any   = I_CMD_VALID && !I_CMD_CODE[7];

	// Per-port change detection on the root port status words
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		assign port_changed[p] = |(I_ROOT_PORT_STATUS[p*PORT_W +: PORT_W]
			^ port_prev_q[p*PORT_W +: PORT_W]);
	end

	// Previous samples load the live value at reset, so no false event on release
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			port_prev_q <= I_ROOT_PORT_STATUS;
			fmsb_prev_q <= I_FRAME_NUMBER[his_pkg::FRAME_MSB];
		end else begin
			port_prev_q <= I_ROOT_PORT_STATUS;
			fmsb_prev_q <= I_FRAME_NUMBER[his_pkg::FRAME_MSB];
		end
	end

	// Resume line comes from the bus, so it is synchronised first
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			resume_s1_q   <= 1'b0;
			resume_s2_q   <= 1'b0;
			resume_prev_q <= 1'b0;
		end else begin
			resume_s1_q   <= I_RESUME_LINE;
			resume_s2_q   <= resume_s1_q;
			resume_prev_q <= resume_s2_q;
		end
	end

	// Software driven resume must not raise the flag
	assign resume_rise = resume_s2_q && !resume_prev_q && !I_BUS_RESUME_STATE;

	always_comb begin
		set_vec                            = 32'h0000_0000;
		set_vec[his_pkg::BIT_ROOT_HUB]     = |port_changed;
		set_vec[his_pkg::BIT_FRAME_WRAP]   = I_FRAME_NUMBER[his_pkg::FRAME_MSB] != fmsb_prev_q;
		set_vec[his_pkg::BIT_FATAL_ERR]    = 1'b0;
		set_vec[his_pkg::BIT_RESUME]       = resume_rise;
		set_vec[his_pkg::BIT_FRAME_BEGIN]  = I_FRAME_START;
		set_vec[his_pkg::BIT_OVERRUN]      = I_SCHED_OVERRUN;
	end

	// Write one clears, write zero keeps; a new event wins over a clear
	assign clr_vec = wr_flags ? (I_WR_DATA & his_pkg::EVENT_MASK) : 32'h0000_0000;
	assign flags_d = ((flags_q & ~clr_vec) | set_vec) & his_pkg::EVENT_MASK;

	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			flags_q <= his_pkg::FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Enables are set-only here; only hardware or software reset clears them
	assign enable_d = wr_mask ? (enable_q | (I_WR_DATA & his_pkg::ENABLE_MASK)) : enable_q;

	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			enable_q <= his_pkg::ENABLE_RESET;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Count wraps from 3 to 0, and counts even with the flag already set
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			ovr_cnt_q <= his_pkg::OVR_CNT_RESET;
		end else if (I_SCHED_OVERRUN) begin
			ovr_cnt_q <= ovr_cnt_q + 2'h1;
		end
	end

	// Registered request, one cycle behind the flag and enable state
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= enable_q[his_pkg::BIT_MASTER_GATE]
				&& |(flags_q & enable_q & his_pkg::EVENT_MASK);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			O_SOF_TOKEN <= 1'b0;
		end else begin
			O_SOF_TOKEN <= I_FRAME_START;
		end
	end

	// Halt follows the fatal flag, which this design never raises
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			O_PROCESS_HALT <= 1'b0;
		end else begin
			O_PROCESS_HALT <= flags_q[his_pkg::BIT_FATAL_ERR];
		end
	end

	always_comb begin
		rd_word = his_pkg::UNMAPPED_READ;
		if (I_CMD_CODE == his_pkg::CMD_RD_FLAGS) begin
			rd_word = flags_q;
		end else if (I_CMD_CODE == his_pkg::CMD_RD_MASK) begin
			rd_word = enable_q;
		end else if (I_CMD_CODE == his_pkg::CMD_RD_CMD_STATUS) begin
			rd_word[his_pkg::OVR_CNT_LSB +: his_pkg::OVR_CNT_W] = ovr_cnt_q;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			O_RD_DATA  <= 32'h0000_0000;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RD_VALID <= rd_any;
			if (rd_any) begin
				O_RD_DATA <= rd_word;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			O_OVERRUN_COUNT <= his_pkg::OVR_CNT_RESET;
		end else begin
			O_OVERRUN_COUNT <= ovr_cnt_q;
		end
	end

endmodule // his_irq

/* core/his_pkg.sv */
// Constants for the host interrupt event and enable block
package his_pkg;
	// Command codes of the register port
	localparam logic [7:0]  CMD_RD_CMD_STATUS = 8'h02;
	localparam logic [7:0]  CMD_RD_FLAGS      = 8'h03;
	localparam logic [7:0]  CMD_WR_FLAGS      = 8'h83;
	localparam logic [7:0]  CMD_RD_MASK       = 8'h04;
	localparam logic [7:0]  CMD_WR_MASK       = 8'h84;

	// Bit positions of event_flag_register and irq_mask_register, and the frame number MSB
	localparam int          BIT_ROOT_HUB      = 6;
	localparam int          BIT_FRAME_WRAP    = 5;
	localparam int          BIT_FATAL_ERR     = 4;
	localparam int          BIT_RESUME        = 3;
	localparam int          BIT_FRAME_BEGIN   = 2;
	localparam int          BIT_OVERRUN       = 0;
	localparam int          BIT_MASTER_GATE   = 31;
	localparam int          FRAME_MSB         = 15;

	// Overrun count field in command_status_register
	localparam int          OVR_CNT_LSB       = 16;
	localparam int          OVR_CNT_W         = 2;

	// Implemented event bits and writable enable bits
	localparam logic [31:0] EVENT_MASK        = 32'h0000_007d;
	localparam logic [31:0] ENABLE_MASK       = 32'h8000_007d;

	// Reset values, and the word read at unmapped codes
	localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET      = 32'h0000_0000;
	localparam logic [1:0]  OVR_CNT_RESET     = 2'h0;
	localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
endpackage : his_pkg

/* sim/his_host_model.sv */
// Host driver model issuing register port commands
module his_host_model (
	input  wire logic        i_clk,      // clock
	input  wire logic        i_rd_valid, // answer strobe
	input  wire logic [31:0] i_rd_data,  // answer word
	output logic             o_valid,    // strobe
	output logic [7:0]       o_code,     // code
	output logic [31:0]      o_data      // write word
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_valid, o_code, o_data} = '0;
	end
	// Writes of one clear flags; fatal flag clears the same way at any time
	task automatic cmd(input logic [7:0] c, input logic [31:0] d, output logic [31:0] r);
		@(negedge i_clk);
		{o_valid, o_code, o_data} = {1'b1, c, d};
		@(negedge i_clk);
		// Released bus shows no stale word
		{o_valid, o_code, o_data} = {1'b0, ~c, ~d};
		r = i_rd_valid ? i_rd_data : 'x;
	endtask
endmodule // his_host_model

/* sim/his_irq_props.sv */
// Port-level assertions for the interrupt event and enable block
module his_irq_props #(
	parameter int ST_W = 64
) (
	input wire logic [ST_W-1:0] I_ROOT_PORT_STATUS, // port words
	input wire logic        I_REF_CLK,       // clock
	input wire logic        I_RST,           // reset
	input wire logic        I_SW_RESET,      // soft reset
	input wire logic        I_CMD_VALID,     // strobe
	input wire logic [7:0]  I_CMD_CODE,      // code
	input wire logic [31:0] I_WR_DATA,       // write word
	input wire logic [15:0] I_FRAME_NUMBER,  // frame
	input wire logic        I_RESUME_LINE,   // resume
	input wire logic        I_FRAME_START,   // frame pulse
	input wire logic        I_SCHED_OVERRUN, // overrun
	input wire logic        O_RD_VALID,      // read strobe
	input wire logic        O_IRQ,           // request
	input wire logic        O_SOF_TOKEN,     // token
	input wire logic [1:0]  O_OVERRUN_COUNT, // count
	input wire logic        O_PROCESS_HALT   // halt
);
	logic gate_q;
	logic was_rst_q;
	wire logic rst = I_RST || I_SW_RESET;
	wire logic rdq = I_CMD_VALID && !I_CMD_CODE[7];
	wire logic clr = I_CMD_VALID && I_CMD_CODE == 8'h83 && I_WR_DATA == 32'hffff_ffff;
	wire logic q = !I_FRAME_START && !I_SCHED_OVERRUN && !I_RESUME_LINE;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (rst);
	// Counters drop in reset, so skip the edge after it
	always_ff @(posedge I_REF_CLK) begin
		was_rst_q <= rst;
	end
	always_ff @(posedge I_REF_CLK) begin
		if (rst) begin
			gate_q <= 1'b0;
		end else if (I_CMD_VALID && I_CMD_CODE == 8'h84 && I_WR_DATA[31]) begin
			gate_q <= 1'b1;
		end
	end
	chk_read_answer: assert property (rdq |=> O_RD_VALID)
		else $error("read not answered");
	chk_no_stray_read: assert property (!rdq |=> !O_RD_VALID)
		else $error("stray read strobe");
	chk_sof_token: assert property (I_FRAME_START |=> O_SOF_TOKEN)
		else $error("token missing");
	chk_sof_only: assert property (!I_FRAME_START |=> !O_SOF_TOKEN)
		else $error("stray token");
	chk_halt_low: assert property (!O_PROCESS_HALT)
		else $error("halt raised");
	chk_irq_gate: assert property (O_IRQ |-> $past(gate_q))
		else $error("request without master gate");
	// Port changes and a resume rise two cycles back would set a flag in the clear cycle
	chk_irq_drop: assert property ((clr && q && $stable(I_FRAME_NUMBER[15])
		&& $stable(I_ROOT_PORT_STATUS) && !$past(I_RESUME_LINE, 2)) ##1
		(q && $stable(I_FRAME_NUMBER[15])) |=> !O_IRQ)
		else $error("request held after clear");
	chk_count_step: assert property (!was_rst_q && $changed(O_OVERRUN_COUNT) |->
		O_OVERRUN_COUNT == $past(O_OVERRUN_COUNT) + 2'h1)
		else $error("count step wrong");
	cover property (O_IRQ);
	cover property (O_SOF_TOKEN);
	cover property (rdq ##1 O_RD_VALID);
endmodule // his_irq_props

bind his_irq his_irq_props #(.ST_W(NUM_PORTS * PORT_W)) his_irq_props_inst (.*);

/* sim/tb.sv */
// Self-checking bench for the interrupt event and enable block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, swr = 0, fs = 0, ovr = 0, rl = 0, rs = 0;
	logic [63:0] port = '0;
	logic [15:0] fn = '0;
	logic        v, rv, irq, sof;
	logic [7:0]  code;
	logic [31:0] wd, rd, r;
	logic [1:0]  cnt;
	int          err_total = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	his_irq his_irq_inst (.I_REF_CLK(clk), .I_RST(rst), .I_SW_RESET(swr), .I_CMD_VALID(v), .I_CMD_CODE(code),
		.I_WR_DATA(wd), .I_ROOT_PORT_STATUS(port), .I_FRAME_NUMBER(fn), .I_RESUME_LINE(rl),
		.I_BUS_RESUME_STATE(rs), .I_FRAME_START(fs), .I_SCHED_OVERRUN(ovr), .O_RD_DATA(rd), .O_RD_VALID(rv),
		.O_IRQ(irq), .O_SOF_TOKEN(sof), .O_OVERRUN_COUNT(cnt), .O_PROCESS_HALT());
	his_host_model his_host_model_inst (.i_clk(clk), .i_rd_valid(rv), .i_rd_data(rd), .o_valid(v),
		.o_code(code), .o_data(wd));
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task automatic chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic io(input logic [7:0] c, input logic [31:0] d);
		his_host_model_inst.cmd(c, d, r);
	endtask
	task automatic rdc(input logic [7:0] c, input logic [31:0] e);
		io(c, 32'h0);
		chk(r, e);
	endtask
	task automatic t_events();
		rdc(8'h11, 32'h0);
		rs = 1;
		rl = 1;
		tick(6);
		rl = 0;
		rs = 0;
		tick(6);
		rdc(8'h03, 32'h0);
		rl = 1;
		tick(6);
		rl = 0;
		pulse(fs);
		chk(sof, 1);
		fn = 16'h8000;
		pulse(ovr);
		port[40] = 1;
		tick(2);
		rdc(8'h03, 32'h0000_006d);
		rdc(8'h02, 32'h0001_0000);
		io(8'h83, 32'h0000_0001);
		io(8'h83, 32'h0);
		rdc(8'h03, 32'h0000_006c);
		$display("events test done");
	endtask
	task automatic t_enable();
		io(8'h84, 32'h0000_0004);
		io(8'h84, 32'h0);
		rdc(8'h04, 32'h0000_0004);
		chk(irq, 0);
		io(8'h84, 32'h8000_0000);
		tick(2);
		chk(irq, 1);
		io(8'h84, 32'h0);
		tick(2);
		chk(irq, 1);
		io(8'h83, 32'h0000_0004);
		tick(2);
		chk(irq, 0);
		io(8'h84, 32'hffff_ffff);
		rdc(8'h04, 32'h8000_007d);
		chk(irq, 1);
		io(8'h83, 32'hffff_ffff);
		tick(2);
		chk(irq, 0);
		rdc(8'h03, 32'h0);
		$display("enable test done");
	endtask
	task automatic t_reset();
		pulse(ovr);
		tick(1);
		pulse(ovr);
		tick(2);
		chk(cnt, 2'h3);
		pulse(swr);
		io(8'h83, 32'h0000_0010);
		rdc(8'h04, 32'h0);
		rdc(8'h03, 32'h0);
		chk(cnt, 2'h0);
		$display("reset test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		tick(5);
		rst = 0;
		t_events();
		t_enable();
		t_reset();
		tally_and_finish();
	end
	// Tests need about 80 cycles; allow fifty times that
	initial begin
		#100us;
		err_total++;
		tally_and_finish();
	end
endmodule // tb
